// File: pal_bridge.sv
// Address-decoded access latency bridge between CPU and peripheral registers
//
// Contract
// RQ1: CPU never touches reserved addresses; such accesses get a default latency.
// RQ2: Latency counted in cycles of the range's own reference clock.
// RQ3: Latency sums bus, clock synchronisation and module wait cycles.
// RQ4: Equal clock rates give a constant synchronisation portion.
// RQ5: Faster core clock adds one peripheral clock cycle of synchronisation.
// RQ6: Same ratio handling for both peripheral clocks.
// RQ7: Other bus masters contending may lengthen accesses.
// RQ8: 4000_0000h to 4000_6FFFh take three core cycles.
// RQ9: Flash and debug 4001_A000h to 4001_CFFFh take three core cycles.
// RQ10: System control outside E400h-E4FFh takes three core cycles.
// RQ11: System control E400h-E4FFh takes five, except three single bytes three.
// RQ12: Ports and event link take three slow cycles, two to three if faster.
// RQ13: RTC, watchdogs, monitor, module stop: three slow cycles, else two-three.
// RQ14: Fractional bounds round minimum down, maximum to nearest.
// RQ15: Sixteen-bit serial FIFO registers take two extra cycles.
// RQ16: System control counts are minimums; clock changes may add cycles.
// RQ17: Decode address, load count, hold completion until count elapses.
`timescale 1ns/1ps
module pal_bridge
  import pal_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Peripheral clock divide settings
  input  wire logic [DIV_W-1:0] fast_div_i,
  input  wire logic [DIV_W-1:0] slow_div_i,
  // Stall sources
  input  wire logic             master_busy_i,
  input  wire logic             clk_change_i,
  // CPU request
  input  wire logic             req_i,
  input  wire logic             we_i,
  input  wire logic [1:0]       size_i,
  input  wire logic [31:0]      addr_i,
  input  wire logic [31:0]      wdata_i,
  // CPU response
  output logic                  busy_o,
  output logic                  ack_o,
  output logic [31:0]           rdata_o,
  // Peripheral side
  output logic                  per_sel_o,
  output logic                  per_we_o,
  output logic [1:0]            per_size_o,
  output logic [31:0]           per_addr_o,
  output logic [31:0]           per_wdata_o,
  output logic [1:0]            per_ref_o,
  input  wire logic [31:0]      per_rdata_i
);

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral clock enables

  logic fast_tick;
  logic slow_tick;

  // Free-running dividers, so the first tick after a take may land anywhere
  // RQ6: twin dividers alike
  pal_tick_div u_fast_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .div_i     (fast_div_i),
    .tick_o    (fast_tick)
  );

  pal_tick_div u_slow_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .div_i     (slow_div_i),
    .tick_o    (slow_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [CNT_W-1:0] dec_lat;
  pal_ref_t         dec_ref;
  logic             sys_byte_exc;

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Single bytes inside the slow span that answer at the short count
  assign sys_byte_exc = (addr_i == SYS_EXC_0) || (addr_i == SYS_EXC_1) ||
                        (addr_i == SYS_EXC_2);

  // RQ17: range table lookup
  always_comb begin
    // Reserved space is never addressed; fall back to a core count
    dec_lat = LAT_DEFAULT;
    dec_ref = REF_CORE;
    // RQ8: core register block
    if (in_rng(addr_i, CORE_A_LO, CORE_A_HI)) begin
      dec_lat = LAT_THREE;
    // RQ9: flash and debug
    end else if (in_rng(addr_i, FLASH_LO, FLASH_HI)) begin
      dec_lat = LAT_THREE;
    // Trace buffer answers one cycle sooner
    end else if (in_rng(addr_i, TRACE_LO, TRACE_HI)) begin
      dec_lat = LAT_TWO;
    end else if (in_rng(addr_i, SYS_LO, SYS_HI)) begin
      // RQ10: system control default span
      dec_lat = LAT_THREE;
      // RQ11: slow span with byte exceptions
      if (in_rng(addr_i, SYS_SLOW_LO, SYS_SLOW_HI) && !sys_byte_exc) begin
        dec_lat = LAT_FIVE;
      end
    // RQ12: ports and event link
    end else if (in_rng(addr_i, GPIO_LO, GPIO_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    end else if (in_rng(addr_i, SER_LO, SER_HI)) begin
      // RQ15: halfword FIFO access costs more
      dec_lat = (size_i == SIZE_HALF) ? (LAT_THREE + LAT_FIFO_EX) : LAT_THREE;
      dec_ref = REF_SLOW;
    // Port output enables
    end else if (in_rng(addr_i, POE_LO, POE_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    // RQ13: timers, watchdogs, module stop
    end else if (in_rng(addr_i, RTC_LO, RTC_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    end else if (in_rng(addr_i, TMR_LO, TMR_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    end else if (in_rng(addr_i, IIC_LO, IIC_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    end else if (in_rng(addr_i, DOC_LO, DOC_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_SLOW;
    // Fast peripheral serial range
    end else if (in_rng(addr_i, FSER_LO, FSER_HI)) begin
      dec_lat = LAT_THREE;
      dec_ref = REF_FAST;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Sequencer state and the taken request
  pal_state_t       state_q;
  pal_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  pal_ref_t         ref_q;
  pal_ref_t         ref_d;
  logic             we_q;
  logic             we_d;
  logic [1:0]       size_q;
  logic [1:0]       size_d;
  logic [31:0]      addr_q;
  logic [31:0]      addr_d;
  logic [31:0]      wdata_q;
  logic [31:0]      wdata_d;
  logic             ack_q;
  logic             ack_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;

  logic             tick;
  logic             slower;
  logic             stall;
  logic             dec_slower;

  // RQ2: pick the reference clock enable
  always_comb begin
    case (ref_q)
      REF_FAST: begin
        tick   = fast_tick;
        slower = (fast_div_i != '0);
      end
      REF_SLOW: begin
        tick   = slow_tick;
        slower = (slow_div_i != '0);
      end
      // Core ranges count every cycle
      default: begin
        tick   = 1'b1;
        slower = 1'b0;
      end
    endcase
  end

  // Ratio of the range being requested, looked at before the take
  always_comb begin
    case (dec_ref)
      REF_FAST: dec_slower = (fast_div_i != '0);
      REF_SLOW: dec_slower = (slow_div_i != '0);
      default:  dec_slower = 1'b0;
    endcase
  end

  // Level inputs on the core clock, so no synchroniser
  // RQ7: contention freezes the count
  // RQ16: clock source change adds cycles
  assign stall = master_busy_i || clk_change_i;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ref_d   = ref_q;
    we_d    = we_q;
    size_d  = size_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    ack_d   = 1'b0;
    rdata_d = rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (req_i) begin
          ref_d   = dec_ref;
          we_d    = we_i;
          size_d  = size_i;
          addr_d  = addr_i;
          wdata_d = wdata_i;
          // RQ5: extra sync phase when core runs faster
          if (dec_slower) begin
            state_d = ST_SYNC;
            cnt_d   = dec_lat - 4'h2;
          end else begin
            // RQ4: fixed count at equal rates
            state_d = ST_COUNT;
            cnt_d   = dec_lat - 4'h1;
          end
        end
      end
      ST_SYNC: begin
        // A stall also holds the access in sync
        // RQ14: partial period yields a span of whole cycles
        if (tick && !stall) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        // RQ3: count bus, sync and wait cycles
        if (tick && !stall) begin
          if (cnt_q == '0) begin
            state_d = ST_IDLE;
            ack_d   = 1'b1;
            // Writes keep the last read data
            rdata_d = we_q ? rdata_q : per_rdata_i;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Ratio may change mid access; re-enter sync only from idle
    if (state_q == ST_SYNC && !slower) begin
      state_d = ST_COUNT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      ref_q   <= REF_CORE;
      we_q    <= 1'b0;
      size_q  <= SIZE_WORD;
      addr_q  <= '0;
      wdata_q <= '0;
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ref_q   <= ref_d;
      we_q    <= we_d;
      size_q  <= size_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // RQ17: completion held off until count ends
  assign ack_o       = ack_q;
  assign busy_o      = (state_q != ST_IDLE);
  assign rdata_o     = rdata_q;
  // Peripheral side holds the taken request until the next take; select is raised only while busy
  assign per_sel_o   = (state_q != ST_IDLE);
  assign per_we_o    = we_q;
  assign per_size_o  = size_q;
  assign per_addr_o  = addr_q;
  assign per_wdata_o = wdata_q;
  assign per_ref_o   = ref_q;

endmodule

// File: pal_pkg.sv
// Constants and types for the peripheral access latency bridge
package pal_pkg;

  // Reference clock of an address range
  typedef enum logic [1:0] {
    REF_CORE,
    REF_FAST,
    REF_SLOW
  } pal_ref_t;

  // Bridge sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC,
    ST_COUNT
  } pal_state_t;

  localparam int unsigned CNT_W  = 4;
  localparam int unsigned DIV_W  = 4;

  // Access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Cycle counts in each range's reference clock
  localparam logic [CNT_W-1:0] LAT_THREE   = 4'h3;
  localparam logic [CNT_W-1:0] LAT_TWO     = 4'h2;
  localparam logic [CNT_W-1:0] LAT_FIVE    = 4'h5;
  localparam logic [CNT_W-1:0] LAT_FIFO_EX = 4'h2;
  localparam logic [CNT_W-1:0] LAT_DEFAULT = 4'h3;

  // Core clock ranges
  localparam logic [31:0] CORE_A_LO  = 32'h4000_0000;
  localparam logic [31:0] CORE_A_HI  = 32'h4000_6FFF;
  localparam logic [31:0] FLASH_LO   = 32'h4001_A000;
  localparam logic [31:0] FLASH_HI   = 32'h4001_CFFF;
  localparam logic [31:0] TRACE_LO   = 32'h4001_9000;
  localparam logic [31:0] TRACE_HI   = 32'h4001_9FFF;
  localparam logic [31:0] SYS_LO     = 32'h4001_E000;
  localparam logic [31:0] SYS_HI     = 32'h4001_EFFF;
  localparam logic [31:0] SYS_SLOW_LO = 32'h4001_E400;
  localparam logic [31:0] SYS_SLOW_HI = 32'h4001_E4FF;
  localparam logic [31:0] SYS_EXC_0  = 32'h4001_E413;
  localparam logic [31:0] SYS_EXC_1  = 32'h4001_E421;
  localparam logic [31:0] SYS_EXC_2  = 32'h4001_E4E1;

  // Slow peripheral clock ranges
  localparam logic [31:0] GPIO_LO    = 32'h4004_0000;
  localparam logic [31:0] GPIO_HI    = 32'h4004_10FF;
  localparam logic [31:0] SER_LO     = 32'h4004_1240;
  localparam logic [31:0] SER_HI     = 32'h4004_133F;
  localparam logic [31:0] POE_LO     = 32'h4004_2000;
  localparam logic [31:0] POE_HI     = 32'h4004_21FF;
  localparam logic [31:0] RTC_LO     = 32'h4004_4000;
  localparam logic [31:0] RTC_HI     = 32'h4004_70FF;
  localparam logic [31:0] TMR_LO     = 32'h4005_2000;
  localparam logic [31:0] TMR_HI     = 32'h4005_207F;
  localparam logic [31:0] IIC_LO     = 32'h4005_3000;
  localparam logic [31:0] IIC_HI     = 32'h4005_31FF;
  localparam logic [31:0] DOC_LO     = 32'h4005_4100;
  localparam logic [31:0] DOC_HI     = 32'h4005_41FF;

  // Fast peripheral clock range
  localparam logic [31:0] FSER_LO    = 32'h4007_0000;
  localparam logic [31:0] FSER_HI    = 32'h4007_003F;

endpackage

// File: pal_tick_div.sv
// Divider producing a one-cycle peripheral clock enable
`timescale 1ns/1ps
module pal_tick_div
  import pal_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Divide setting, zero means equal to core clock
  input  wire logic [DIV_W-1:0] div_i,
  // Enable pulse
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  always_comb begin
    if (cnt_q == '0) begin
      cnt_d = div_i;
    end else begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = (cnt_q == '0);

endmodule

// File: pal_bridge_chk.sv
// Assertion checker for the access latency bridge
`timescale 1ns/1ps
module pal_bridge_chk
  import pal_pkg::*;
(
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  // CPU side
  input wire logic [DIV_W-1:0] fast_div_i,
  input wire logic [DIV_W-1:0] slow_div_i,
  input wire logic             master_busy_i,
  input wire logic             clk_change_i,
  input wire logic             req_i,
  input wire logic             we_i,
  input wire logic [31:0]      addr_i,
  input wire logic             busy_o,
  input wire logic             ack_o,
  input wire logic [31:0]      rdata_o,
  // Peripheral side
  input wire logic             per_sel_o,
  input wire logic             per_we_o,
  input wire logic [1:0]       per_size_o,
  input wire logic [31:0]      per_addr_o,
  input wire logic [1:0]       per_ref_o,
  input wire logic [31:0]      per_rdata_i
);
  logic [7:0] run_q, run_d;
  logic       stl_q, stl_d;
  int         lat, dv;
  function automatic bit inr(logic [31:0] a, logic [31:0] lo, logic [31:0] hi);
    return a >= lo && a <= hi;
  endfunction
  function automatic int lat_of(logic [31:0] a, logic [1:0] s);
    if (inr(a, TRACE_LO, TRACE_HI)) return 2;
    if (inr(a, SYS_SLOW_LO, SYS_SLOW_HI) && a != SYS_EXC_0 && a != SYS_EXC_1 && a != SYS_EXC_2) return 5;
    if (inr(a, SER_LO, SER_HI) && s == SIZE_HALF) return 5;
    return 3;
  endfunction
  // Gaps between slow ranges are reserved, so one span suffices
  function automatic logic [1:0] ref_of(logic [31:0] a);
    if (inr(a, FSER_LO, FSER_HI)) return 2'h1;
    if (inr(a, GPIO_LO, DOC_HI)) return 2'h2;
    return 2'h0;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Busy cycles of this access; any stall voids the exact count
  always_comb begin
    run_d = busy_o ? run_q + 8'h01 : run_q;
    stl_d = stl_q | (busy_o & (master_busy_i | clk_change_i));
    if (sys_rst_i || (req_i && !busy_o)) begin
      run_d = 8'h00;
      stl_d = 1'b0;
    end
    lat = lat_of(per_addr_o, per_size_o);
    dv  = (per_ref_o == 2'h1) ? int'(fast_div_i) : int'(slow_div_i);
  end
  always_ff @(posedge clk_i) begin
    run_q <= run_d;
    stl_q <= stl_d;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack wider than one cycle");
  AST_BUSY_END: assert property ($fell(busy_o) |-> ack_o && !per_sel_o)
    else $error("busy ended without ack");
  AST_TAKE: assert property (req_i && !busy_o |=> per_sel_o && per_addr_o == $past(addr_i) && per_we_o == $past(we_i))
    else $error("request not taken");
  AST_REF: assert property (busy_o |-> per_ref_o == ref_of(per_addr_o))
    else $error("wrong reference clock");
  AST_CORE_LAT: assert property (ack_o && per_ref_o == 2'h0 && !stl_q |-> run_q == lat)
    else $error("core latency wrong");
  AST_EQ_LAT: assert property (ack_o && per_ref_o != 2'h0 && dv == 0 && !stl_q |-> run_q == lat)
    else $error("equal rate latency wrong");
  AST_DIV_LAT: assert property (ack_o && per_ref_o != 2'h0 && dv != 0 && !stl_q |->
    run_q >= (lat - 1) * (dv + 1) && run_q <= lat * (dv + 1) + 1)
    else $error("divided latency out of span");
  AST_STALL: assert property (busy_o && per_ref_o == 2'h0 && (master_busy_i || clk_change_i) |=> !ack_o)
    else $error("stall did not hold completion");
  AST_RDATA: assert property (ack_o && !per_we_o |-> rdata_o == $past(per_rdata_i))
    else $error("read data not captured");
  AST_WR_HOLD: assert property (ack_o && per_we_o |-> $stable(rdata_o))
    else $error("write changed read data");
endmodule

bind pal_bridge pal_bridge_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fast_div_i(fast_div_i), .slow_div_i(slow_div_i),
  .master_busy_i(master_busy_i), .clk_change_i(clk_change_i), .req_i(req_i), .we_i(we_i),
  .addr_i(addr_i), .busy_o(busy_o), .ack_o(ack_o), .rdata_o(rdata_o), .per_sel_o(per_sel_o),
  .per_we_o(per_we_o), .per_size_o(per_size_o), .per_addr_o(per_addr_o), .per_ref_o(per_ref_o),
  .per_rdata_i(per_rdata_i)
);

// File: pal_per_model.sv
// Peripheral register side model returning address-derived read data
`timescale 1ns/1ps
module pal_per_model
  import pal_pkg::*;
(
  // Clock and access
  input  wire logic        clk_i,
  input  wire logic        sel_i,
  input  wire logic [31:0] addr_i,
  // Read data
  output logic [31:0]      rdata_o
);
  logic [31:0] nz_q = 32'h1357_9BDF;
  logic [31:0] nz_d;
  // Churn while unselected so a stale value never looks right
  always_comb nz_d = {nz_q[30:0], ~nz_q[31]};
  always_ff @(posedge clk_i) nz_q <= nz_d;
  assign rdata_o = sel_i ? (addr_i ^ 32'hC3C3_0F0F) : nz_q;
endmodule

// File: testbench.sv
// Self-checking bench for the access latency bridge
`timescale 1ns/1ps
module testbench
  import pal_pkg::*;
;
  localparam int    NT = 24;
  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [DIV_W-1:0] fast_div_i = 4'h0;
  logic [DIV_W-1:0] slow_div_i = 4'h0;
  logic             master_busy_i = 1'b0;
  logic             clk_change_i = 1'b0;
  logic             req_i = 1'b0;
  logic             we_i = 1'b0;
  logic [1:0]       size_i = 2'h2;
  logic [31:0]      addr_i = 32'h0;
  logic [31:0]      wdata_i = 32'h0;
  logic             busy_o, ack_o, per_sel_o, per_we_o;
  logic [1:0]       per_size_o, per_ref_o;
  logic [31:0]      rdata_o, per_addr_o, per_wdata_o, per_rdata_i;
  int               err_count = 0;
  int               n_checks = 0;
  // Address, size, cycles, reference clock
  // mapped addresses only
  logic [31:0] ta [NT] = '{32'h4000_0000, 32'h4000_6FFF, 32'h4001_9000, 32'h4001_A000, 32'h4001_CFFF,
    32'h4001_E000, 32'h4001_E3FF, 32'h4001_E400, 32'h4001_E412, 32'h4001_E413, 32'h4001_E414, 32'h4001_E421,
    32'h4001_E4E1, 32'h4001_E4FF, 32'h4001_E500, 32'h4001_EFFF, 32'h4004_0000, 32'h4004_10FF, 32'h4004_4000,
    32'h4004_70FF, 32'h4004_1240, 32'h4004_1241, 32'h4007_0000, 32'h4005_41FF};
  logic [1:0]  ts [NT] = '{2, 0, 2, 2, 0, 2, 0, 2, 0, 0, 0, 0, 0, 0, 2, 0, 2, 0, 2, 0, 1, 0, 2, 2};
  int          tn [NT] = '{3, 3, 2, 3, 3, 3, 3, 5, 5, 3, 5, 3, 3, 5, 3, 3, 3, 3, 3, 3, 5, 3, 3, 3};
  int          tr [NT] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2, 2, 2, 2, 1, 2};

  always #12.5 clk_i = ~clk_i;

  pal_bridge dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fast_div_i(fast_div_i), .slow_div_i(slow_div_i),
    .master_busy_i(master_busy_i), .clk_change_i(clk_change_i), .req_i(req_i), .we_i(we_i), .size_i(size_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .ack_o(ack_o), .rdata_o(rdata_o), .per_sel_o(per_sel_o),
    .per_we_o(per_we_o), .per_size_o(per_size_o), .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o),
    .per_ref_o(per_ref_o), .per_rdata_i(per_rdata_i));
  pal_per_model u_per (.clk_i(clk_i), .sel_i(per_sel_o), .addr_i(per_addr_o), .rdata_o(per_rdata_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Divided-clock span in core cycles for lat reference cycles of period d+1
  function automatic bit in_span(input int n, input int lat, input int d);
    return (n >= (lat - 1) * (d + 1)) && (n <= lat * (d + 1) + 1);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One access from a falling edge; stalls cycles 1..k, optional refused request
  task automatic access(input int i, input int k, input bit alt, input bit refuse, output int n);
    logic [31:0] wd;
    logic        w;
    w = 1'($urandom_range(1, 0));
    wd = $urandom;
    req_i = 1'b1;
    we_i = w;
    size_i = ts[i];
    addr_i = ta[i];
    wdata_i = wd;
    n = 0;
    @(posedge clk_i);
    // n counts edges after the take, so an ack raised at edge N stops with n = N
    while (n < 300) begin
      @(negedge clk_i);
      if (ack_o === 1'b1) break;
      n++;
      // Refused: a second mapped request while busy
      if (n == 1 && refuse) addr_i = ta[i ^ 1];
      else req_i = 1'b0;
      master_busy_i = n <= k && !alt;
      clk_change_i = n <= k && alt;
    end
    check(per_addr_o, ta[i]);
    check(32'(per_ref_o), tr[i]);
    check(32'(per_size_o), 32'(ts[i]));
    check(32'(busy_o), 32'h0);
    if (w) check(per_wdata_o, wd);
    else check(rdata_o, ta[i] ^ 32'hC3C3_0F0F);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int i;
    int d;
    void'($urandom(14));
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (int j = 0; j < NT; j++) begin
      access(j, 0, 1'b0, 1'b0, n);
      check(n, tn[j]);
    end
    $display("test equal rates done");
    for (int j = 0; j < 40; j++) begin
      @(negedge clk_i);
      fast_div_i = 4'($urandom_range(7, 1));
      slow_div_i = 4'($urandom_range(7, 1));
      i = (j % 4 == 0) ? 22 : $urandom_range(NT - 1, 0);
      access(i, 0, 1'b0, 1'b0, n);
      d = (tr[i] == 1) ? fast_div_i : slow_div_i;
      if (tr[i] == 0) check(n, tn[i]);
      else check(32'(in_span(n, tn[i], d)), 32'h1);
    end
    $display("test divided clocks done");
    @(negedge clk_i);
    fast_div_i = 4'h0;
    slow_div_i = 4'h0;
    access(0, 2, 1'b0, 1'b1, n);
    check(n, 5);
    access(7, 1, 1'b1, 1'b0, n);
    check(n, 6);
    $display("test stalls done");
    give_verdict();
  end
  // Tests need under two thousand cycles; 20000 means a hang
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule
